// *** rsr_exec.sv ***
// Execution sequencer for carry clear, return, the four rotates and subtract with carry.
// Assumes a single-port register file whose read data is valid in the cycle mem_rd is high,
// and a decoder that hands over full register addresses in the operand fields.
//
// Operation
// RULE1 - carry clear zeroes carry, others kept
// RULE2 - return pops counter, stack pointer plus two
// RULE3 - byte at stack pointer is counter high
// RULE4 - rotate left: bit 7 to bit 0, carry
// RULE5 - rotate left through carry: carry in, bit7 out
// RULE6 - rotate right: bit 0 to bit 7, carry
// RULE7 - rotate right through carry: bit0 out, carry in
// RULE8 - rotate overflow when sign bit changed
// RULE9 - rotate zero and sign from result
// RULE10 - subtract destination, source and carry; write destination
// RULE11 - subtract by adding source complement
// RULE12 - subtract carry means borrow occurred
// RULE13 - subtract overflow: opposite signs, result matches source
// RULE14 - subtract sign negative, zero on zero
// RULE15 - indirect forms use register as pointer
`timescale 1ns/10ps
`default_nettype none
module rsr_exec
	import rsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Instruction hand-over from the decoder
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] dst_field,
	input wire logic [7:0] src_field,
	output logic busy,
	output logic done,
	// Register file and stack bus
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// Processor state loads from other instructions
	input wire logic flags_load,
	input wire logic [3:0] flags_in,
	input wire logic pc_load,
	input wire logic [15:0] pc_in,
	input wire logic sp_load,
	input wire logic [7:0] sp_in,
	// Processor state
	output logic [3:0] flags,
	output logic [15:0] program_counter,
	output logic [7:0] stack_pointer
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DST_PTR,
		ST_DST,
		ST_SRC_PTR,
		ST_SRC,
		ST_RET_HI,
		ST_RET_LO,
		ST_HOLD
	} rsr_state_t;

	rsr_state_t state_reg, state_next;
	logic [7:0] opc_reg, opc_next;
	logic [7:0] src_reg, src_next;
	logic [7:0] daddr_reg, daddr_next;
	logic [7:0] dval_reg, dval_next;
	logic [3:0] need_reg, need_next;
	logic [3:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic rd_reg, rd_next;
	logic wr_reg, wr_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [3:0] flags_reg, flags_next;
	logic [15:0] pc_reg, pc_next;
	logic [7:0] sp_reg, sp_next;

	logic [7:0] alu_src;
	logic [7:0] alu_result;
	logic [3:0] alu_flags;
	rsr_kind_t kind;

	// Immediate source bypasses the bus; otherwise the fetched byte is the source
	assign alu_src = (state_reg == ST_SRC) ? mem_rdata : src_reg;
	assign kind = op_kind(opc_reg);

	rsr_alu u_alu (
		.sel(op_alu(opc_reg)),
		.dst(state_reg == ST_DST ? mem_rdata : dval_reg),
		.src(alu_src),
		.carry_in(flags_reg[FLAG_C]),
		.result(alu_result),
		.flags(alu_flags)
	);

	always_comb begin
		state_next = state_reg;
		opc_next = opc_reg;
		src_next = src_reg;
		daddr_next = daddr_reg;
		dval_next = dval_reg;
		need_next = need_reg;
		cnt_next = (cnt_reg == 4'hf) ? cnt_reg : cnt_reg + 4'h1;
		busy_next = busy_reg;
		done_next = 1'b0;
		rd_next = 1'b0;
		wr_next = 1'b0;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		flags_next = flags_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		case (state_reg)
			ST_IDLE: begin
				if (flags_load) begin
					flags_next = flags_in;
				end
				if (pc_load) begin
					pc_next = pc_in;
				end
				if (sp_load) begin
					sp_next = sp_in;
				end
				// Unknown opcodes are not taken: busy stays low and no done follows
				if (start && op_kind(opcode) != KIND_NONE) begin
					opc_next = opcode;
					src_next = src_field;
					daddr_next = dst_field;
					need_next = op_cycles(opcode);
					cnt_next = 4'h0;
					busy_next = 1'b1;
					case (op_kind(opcode))
						KIND_CARRY_CLEAR: begin
							flags_next[FLAG_C] = 1'b0; // RULE1
							state_next = ST_HOLD;
						end
						KIND_RETURN: begin
							rd_next = 1'b1; // RULE2
							addr_next = sp_reg;
							state_next = ST_RET_HI;
						end
						default: begin
							rd_next = 1'b1;
							addr_next = dst_field;
							// Rotates with an odd opcode reach their operand through a pointer
							if (op_kind(opcode) == KIND_ROTATE && opcode[0]) begin
								state_next = ST_DST_PTR; // RULE15
							end else begin
								state_next = ST_DST;
							end
						end
					endcase
				end
			end
			ST_DST_PTR: begin
				rd_next = 1'b1; // RULE15
				addr_next = mem_rdata;
				daddr_next = mem_rdata;
				state_next = ST_DST;
			end
			ST_DST: begin
				dval_next = mem_rdata;
				if (kind == KIND_ROTATE || opc_reg == OPC_SUBB_IMM) begin
					wr_next = 1'b1; // RULE10
					addr_next = daddr_reg;
					wdata_next = alu_result;
					flags_next = alu_flags; // RULE9
					state_next = ST_HOLD;
				end else begin
					rd_next = 1'b1;
					addr_next = src_reg;
					if (opc_reg == OPC_SUBB_WORK_PTR || opc_reg == OPC_SUBB_PTR) begin
						state_next = ST_SRC_PTR; // RULE15
					end else begin
						state_next = ST_SRC;
					end
				end
			end
			ST_SRC_PTR: begin
				rd_next = 1'b1; // RULE15
				addr_next = mem_rdata;
				state_next = ST_SRC;
			end
			ST_SRC: begin
				// Only the destination is written; the source byte stays as it was
				wr_next = 1'b1; // RULE10
				addr_next = daddr_reg;
				wdata_next = alu_result;
				flags_next = alu_flags; // RULE12 RULE13 RULE14
				state_next = ST_HOLD;
			end
			ST_RET_HI: begin
				pc_next[15:8] = mem_rdata; // RULE3
				rd_next = 1'b1;
				addr_next = sp_reg + 8'h01; // RULE3
				state_next = ST_RET_LO;
			end
			ST_RET_LO: begin
				pc_next[7:0] = mem_rdata; // RULE3
				sp_next = sp_reg + SP_RETURN_STEP; // RULE2
				state_next = ST_HOLD;
			end
			ST_HOLD: begin
				// Pads the instruction to its least length so timing matches the core
				if (cnt_reg >= need_reg - 4'h1) begin
					done_next = 1'b1;
					busy_next = 1'b0;
					state_next = ST_IDLE;
				end
			end
			default: begin
				busy_next = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			opc_reg <= 8'h00;
			src_reg <= 8'h00;
			daddr_reg <= 8'h00;
			dval_reg <= 8'h00;
			need_reg <= 4'h0;
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			flags_reg <= FLAGS_RESET;
			pc_reg <= PC_RESET;
			sp_reg <= SP_RESET;
		end else begin
			state_reg <= state_next;
			opc_reg <= opc_next;
			src_reg <= src_next;
			daddr_reg <= daddr_next;
			dval_reg <= dval_next;
			need_reg <= need_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			flags_reg <= flags_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign mem_rd = rd_reg;
	assign mem_wr = wr_reg;
	assign mem_addr = addr_reg;
	assign mem_wdata = wdata_reg;
	assign flags = flags_reg;
	assign program_counter = pc_reg;
	assign stack_pointer = sp_reg;

endmodule : rsr_exec
`default_nettype wire

// *** rsr_pkg.sv ***
// Constants and types shared by the rotate / subtract / return execution datapath.
// Assumes an 8-bit register file and stack reached over one single-port bus.
package rsr_pkg;

	// Opcodes handled by this block
	localparam logic [7:0] OPC_CARRY_CLEAR = 8'hcf;
	localparam logic [7:0] OPC_RETURN = 8'haf;
	localparam logic [7:0] OPC_ROTL_DIR = 8'h90;
	localparam logic [7:0] OPC_ROTL_IND = 8'h91;
	localparam logic [7:0] OPC_ROTLC_DIR = 8'h10;
	localparam logic [7:0] OPC_ROTLC_IND = 8'h11;
	localparam logic [7:0] OPC_ROTR_DIR = 8'he0;
	localparam logic [7:0] OPC_ROTR_IND = 8'he1;
	localparam logic [7:0] OPC_ROTRC_DIR = 8'hc0;
	localparam logic [7:0] OPC_ROTRC_IND = 8'hc1;
	localparam logic [7:0] OPC_SUBB_WORK = 8'h32;
	localparam logic [7:0] OPC_SUBB_WORK_PTR = 8'h33;
	localparam logic [7:0] OPC_SUBB_REG = 8'h34;
	localparam logic [7:0] OPC_SUBB_PTR = 8'h35;
	localparam logic [7:0] OPC_SUBB_IMM = 8'h36;

	// Least instruction lengths in clock cycles
	localparam logic [3:0] CYC_CARRY_CLEAR = 4'h4;
	localparam logic [3:0] CYC_RETURN = 4'h8;
	localparam logic [3:0] CYC_ROTATE = 4'h4;
	localparam logic [3:0] CYC_SUBB_SHORT = 4'h4;
	localparam logic [3:0] CYC_SUBB_LONG = 4'h6;

	// Flag bit positions in the flag vector
	localparam int FLAG_C = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_S = 1;
	localparam int FLAG_V = 0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Reset values of the program counter and stack pointer, and the return pointer step
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h00;
	localparam logic [7:0] SP_RETURN_STEP = 8'h02;

	typedef enum logic [2:0] {
		ALU_ROTL,
		ALU_ROTLC,
		ALU_ROTR,
		ALU_ROTRC,
		ALU_SUBB
	} rsr_alu_sel_t;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_CARRY_CLEAR,
		KIND_RETURN,
		KIND_ROTATE,
		KIND_SUBB
	} rsr_kind_t;

	// Which family an opcode belongs to
	function automatic rsr_kind_t op_kind(input logic [7:0] opc);
		case (opc)
			OPC_CARRY_CLEAR: op_kind = KIND_CARRY_CLEAR;
			OPC_RETURN: op_kind = KIND_RETURN;
			OPC_ROTL_DIR, OPC_ROTL_IND, OPC_ROTLC_DIR, OPC_ROTLC_IND,
			OPC_ROTR_DIR, OPC_ROTR_IND, OPC_ROTRC_DIR, OPC_ROTRC_IND: op_kind = KIND_ROTATE;
			OPC_SUBB_WORK, OPC_SUBB_WORK_PTR, OPC_SUBB_REG, OPC_SUBB_PTR,
			OPC_SUBB_IMM: op_kind = KIND_SUBB;
			default: op_kind = KIND_NONE;
		endcase
	endfunction : op_kind

	// Arithmetic unit selection for an opcode
	function automatic rsr_alu_sel_t op_alu(input logic [7:0] opc);
		case (opc)
			OPC_ROTL_DIR, OPC_ROTL_IND: op_alu = ALU_ROTL;
			OPC_ROTLC_DIR, OPC_ROTLC_IND: op_alu = ALU_ROTLC;
			OPC_ROTR_DIR, OPC_ROTR_IND: op_alu = ALU_ROTR;
			OPC_ROTRC_DIR, OPC_ROTRC_IND: op_alu = ALU_ROTRC;
			default: op_alu = ALU_SUBB;
		endcase
	endfunction : op_alu

	// Least length of an instruction
	function automatic logic [3:0] op_cycles(input logic [7:0] opc);
		case (op_kind(opc))
			KIND_CARRY_CLEAR: op_cycles = CYC_CARRY_CLEAR;
			KIND_RETURN: op_cycles = CYC_RETURN;
			KIND_ROTATE: op_cycles = CYC_ROTATE;
			default: op_cycles = (opc == OPC_SUBB_WORK) ? CYC_SUBB_SHORT : CYC_SUBB_LONG;
		endcase
	endfunction : op_cycles

endpackage : rsr_pkg

// *** rsr_alu.sv ***
// Combinational rotate and subtract-with-carry unit with flag generation.
// Assumes the caller registers the result and the flags.
`timescale 1ns/10ps
`default_nettype none
module rsr_alu
	import rsr_pkg::*;
(
	// Selection and operands
	input wire rsr_alu_sel_t sel,
	input wire logic [7:0] dst,
	input wire logic [7:0] src,
	input wire logic carry_in,
	// Result and flags
	output logic [7:0] result,
	output logic [3:0] flags
);

	logic [8:0] sum;

	always_comb begin
		// Adding the complement plus the inverted carry keeps the borrow chainable
		sum = {1'b0, dst} + {1'b0, ~src} + {8'h00, ~carry_in}; // RULE11
		result = dst;
		flags = FLAGS_RESET;
		case (sel)
			ALU_ROTL: begin
				result = {dst[6:0], dst[7]}; // RULE4
				flags[FLAG_C] = dst[7]; // RULE4
			end
			ALU_ROTLC: begin
				result = {dst[6:0], carry_in}; // RULE5
				flags[FLAG_C] = dst[7]; // RULE5
			end
			ALU_ROTR: begin
				result = {dst[0], dst[7:1]}; // RULE6
				flags[FLAG_C] = dst[0]; // RULE6
			end
			ALU_ROTRC: begin
				result = {carry_in, dst[7:1]}; // RULE7
				flags[FLAG_C] = dst[0]; // RULE7
			end
			ALU_SUBB: begin
				result = sum[7:0]; // RULE10
				// No carry out of the add means a borrow was taken
				flags[FLAG_C] = ~sum[8]; // RULE12
			end
			default: begin
				result = dst;
			end
		endcase
		if (sel == ALU_SUBB) begin
			flags[FLAG_V] = (dst[7] != src[7]) && (result[7] == src[7]); // RULE13
		end else begin
			flags[FLAG_V] = dst[7] != result[7]; // RULE8
		end
		flags[FLAG_Z] = result == 8'h00; // RULE9 RULE14
		flags[FLAG_S] = result[7]; // RULE9 RULE14
	end

endmodule : rsr_alu
`default_nettype wire

// *** rsr_regfile_model.sv ***
// Register file and stack memory on the sequencer's single-port bus.
// Assumes read data is wanted in the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module rsr_regfile_model (
	// Clock
	input wire logic clk_sys,
	// Bus
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last = 8'h00;
	// Idle bus shows the inverse of the last byte, so a late sample cannot pass
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
	always @(posedge clk_sys) begin
		if (mem_rd) last <= mem[mem_addr];
		if (mem_wr) mem[mem_addr] <= mem_wdata;
	end
endmodule : rsr_regfile_model
`default_nettype wire

// *** rsr_exec_properties.sv ***
// Timing and flag checks for the execution sequencer.
// Assumes it is bound to every rsr_exec instance.
`timescale 1ns/10ps
`default_nettype none
module rsr_exec_properties
	import rsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Decoder side
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic busy,
	input wire logic done,
	input wire logic flags_load,
	// Bus and state
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic [3:0] flags,
	input wire logic [7:0] stack_pointer
);
	logic [7:0] op_q;
	logic [7:0] rd_q;
	logic go;
	logic rot;
	logic subb;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	assign go = start && !busy;
	assign rot = {op_q[7:1], 1'b0} inside {OPC_ROTL_DIR, OPC_ROTLC_DIR, OPC_ROTR_DIR, OPC_ROTRC_DIR};
	assign subb = op_q inside {[OPC_SUBB_WORK:OPC_SUBB_IMM]};
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			op_q <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			if (go) op_q <= opcode;
			if (mem_rd) rd_q <= mem_rdata;
		end
	end
	property p_cc_carry;
		go && opcode == OPC_CARRY_CLEAR && !flags_load |=>
			!flags[FLAG_C] && flags[2:0] == $past(flags[2:0]);
	endproperty
	a_cc_carry: assert property (p_cc_carry) else $error("carry clear");
	property p_cc_done;
		go && opcode == OPC_CARRY_CLEAR |=> ##4 done;
	endproperty
	a_cc_done: assert property (p_cc_done) else $error("carry clear length");
	property p_ret_sp;
		go && opcode == OPC_RETURN |-> ##3 stack_pointer == $past(stack_pointer, 3) + 8'h02;
	endproperty
	a_ret_sp: assert property (p_ret_sp) else $error("return pointer step");
	property p_ret_flags;
		go && opcode == OPC_RETURN && !flags_load |=> $stable(flags)[*7];
	endproperty
	a_ret_flags: assert property (p_ret_flags) else $error("return flags");
	property p_ret_rd;
		go && opcode == OPC_RETURN |=> mem_rd && mem_addr == $past(stack_pointer)
			##1 mem_rd && mem_addr == $past(stack_pointer, 2) + 8'h01;
	endproperty
	a_ret_rd: assert property (p_ret_rd) else $error("return reads");
	property p_rot_left;
		mem_wr && op_q[7:1] == OPC_ROTL_DIR[7:1] |->
			mem_wdata == {rd_q[6:0], rd_q[7]} && flags[FLAG_C] == rd_q[7];
	endproperty
	a_rot_left: assert property (p_rot_left) else $error("rotate left");
	property p_rot_right;
		mem_wr && op_q[7:1] == OPC_ROTR_DIR[7:1] |->
			mem_wdata == {rd_q[0], rd_q[7:1]} && flags[FLAG_C] == rd_q[0];
	endproperty
	a_rot_right: assert property (p_rot_right) else $error("rotate right");
	property p_rot_v;
		mem_wr && rot |-> flags[FLAG_V] == (mem_wdata[7] ^ rd_q[7]);
	endproperty
	a_rot_v: assert property (p_rot_v) else $error("rotate overflow");
	property p_rot_zs;
		mem_wr && rot |-> flags[FLAG_Z] == (mem_wdata == 8'h00) && flags[FLAG_S] == mem_wdata[7];
	endproperty
	a_rot_zs: assert property (p_rot_zs) else $error("rotate zero sign");
	property p_sub_zs;
		mem_wr && subb |-> flags[FLAG_Z] == (mem_wdata == 8'h00) && flags[FLAG_S] == mem_wdata[7];
	endproperty
	a_sub_zs: assert property (p_sub_zs) else $error("subtract zero sign");
endmodule : rsr_exec_properties
bind rsr_exec rsr_exec_properties u_props (.clk_sys, .rst, .start, .opcode, .busy, .done,
	.flags_load, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .flags, .stack_pointer);
`default_nettype wire

// *** test_rsr_exec.sv ***
// Random instruction stream against a behavioural model of the datapath.
// Assumes each accepted start finishes within twenty cycles.
`timescale 1ns/10ps
`default_nettype none
module test_rsr_exec
	import rsr_pkg::*;
();
	localparam logic [7:0] OPS [15] = '{OPC_CARRY_CLEAR, OPC_RETURN, OPC_ROTL_DIR, OPC_ROTL_IND,
		OPC_ROTLC_DIR, OPC_ROTLC_IND, OPC_ROTR_DIR, OPC_ROTR_IND, OPC_ROTRC_DIR, OPC_ROTRC_IND,
		OPC_SUBB_WORK, OPC_SUBB_WORK_PTR, OPC_SUBB_REG, OPC_SUBB_PTR, OPC_SUBB_IMM};
	logic clk_sys = 0, rst = 1, start = 0, flags_load = 0, pc_load = 0, sp_load = 0;
	logic [7:0] opcode = 0, dst_field = 0, src_field = 0, sp_in = 0;
	logic [3:0] flags_in = 0;
	logic [15:0] pc_in = 0;
	logic busy, done, mem_rd, mem_wr;
	logic [7:0] mem_addr, mem_wdata, mem_rdata, stack_pointer;
	logic [3:0] flags;
	logic [15:0] program_counter;
	logic [31:0] seed = 66, x;
	int m [256];
	int mf, mpc, msp, fail_count = 0, cmp_count = 0;
	rsr_exec u_dut (.clk_sys, .rst, .start, .opcode, .dst_field, .src_field, .busy, .done,
		.mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .flags_load, .flags_in,
		.pc_load, .pc_in, .sp_load, .sp_in, .flags, .program_counter, .stack_pointer);
	rsr_regfile_model u_mem (.clk_sys, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input string nm, input int e, input logic [15:0] g);
		cmp_count++;
		if (g !== 16'(e)) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, 16'(e), g);
		end
	endtask : chk
	task test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task model(input int op, d, s, output int wa, n);
		int c, a, r, rr, cn, sv, v;
		c = mf >> 3 & 1;
		wa = -1;
		n = 4;
		case (op)
			OPC_CARRY_CLEAR: mf &= 7;
			OPC_RETURN: begin
				mpc = m[msp] << 8 | m[(msp + 1) & 255];
				msp = (msp + 2) & 255;
				n = 8;
			end
			OPC_SUBB_WORK, OPC_SUBB_WORK_PTR, OPC_SUBB_REG, OPC_SUBB_PTR, OPC_SUBB_IMM: begin
				sv = op == OPC_SUBB_IMM ? s : (op[0] ? m[m[s]] : m[s]);
				r = m[d] - sv - c;
				rr = r & 255;
				cn = r < 0;
				v = ((m[d] ^ sv) & ~(rr ^ sv) & 128) != 0;
				wa = d;
				n = op == OPC_SUBB_WORK ? 4 : 6;
			end
			default: begin
				a = op[0] ? m[m[d]] : m[d];
				wa = op[0] ? m[d] : d;
				cn = op[6] ? a & 1 : a >> 7;
				rr = op[6] ? a >> 1 | (op[5] ? a & 1 : c) << 7 : (a << 1 & 255) | (op[7] ? a >> 7 : c);
				v = ((a ^ rr) & 128) != 0;
			end
		endcase
		if (wa >= 0) begin
			mf = cn << 3 | (rr == 0) << 2 | (rr >> 7) << 1 | v;
			m[wa] = rr;
		end
	endtask : model
	// Starts at a falling edge; while busy it offers a refused start and loads
	task run(input int op, d, s);
		int wa, n, k;
		{start, flags_load, sp_load, pc_load} <= 4'h8;
		opcode <= 8'(op);
		dst_field <= 8'(d);
		src_field <= 8'(s);
		model(op, d, s, wa, n);
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
			if (k == 1) chk("busy", 1, 16'(busy));
			if (done !== 1'b1) begin
				{start, flags_load, sp_load, pc_load} <= 4'hf;
				opcode <= OPC_CARRY_CLEAR;
				{pc_in, sp_in, flags_in} <= 28'(rnd());
			end
		end while (done !== 1'b1 && k < 20);
		// Done rises at the n-th edge after the start edge and is seen one falling edge later
		chk("cycles", n, 16'(k - 1));
		chk("idle", 0, 16'(busy));
		chk("flags", mf, 16'(flags));
		chk("pc", mpc, program_counter);
		chk("sp", msp, 16'(stack_pointer));
		chk("src", m[s], 16'(u_mem.mem[s]));
		if (wa >= 0) chk("data", m[wa], 16'(u_mem.mem[wa]));
	endtask : run
	initial begin
		#1000000;
		fail_count++;
		test_done();
	end
	initial begin
		for (int i = 0; i < 256; i++) begin
			m[i] = rnd() & 255;
			u_mem.mem[i] = 8'(m[i]);
		end
		repeat (10) @(negedge clk_sys);
		rst = 0;
		chk("reset", 0, {flags, stack_pointer} | program_counter | {busy, done, mem_rd, mem_wr});
		x = rnd();
		{pc_in, sp_in, flags_in} <= x[27:0];
		{flags_load, sp_load, pc_load} <= 3'h7;
		mpc = x[27:12];
		msp = x[11:4];
		mf = x[3:0];
		@(negedge clk_sys);
		for (int i = 0; i < 300; i++) begin
			x = rnd();
			run(OPS[x % 15], x[15:8], x[23:16]);
		end
		// An opcode outside the handled set must raise neither busy nor done
		{start, flags_load, sp_load, pc_load} <= 4'h8;
		opcode <= 8'hff;
		repeat (3) begin
			@(negedge clk_sys);
			chk("refused", 0, 16'({busy, done}));
		end
		start <= 1'b0;
		test_done();
	end
endmodule : test_rsr_exec
`default_nettype wire
